//--- axph_axis.sv
// Purpose: one motion axis: moves, jog, home search, feed-forward
// Assumes: APB slave, 10 MHz pclk, inputs synchronous to pclk
// Notes: no APB wait states; profile updates once per servo cycle, except the index stop
`timescale 1ns/1ps
module axph_axis (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder, switch and buttons
  input wire axph_pkg::axph_enc_t enc,
  input wire axph_pkg::axph_man_t man,
  // Driver and panel
  output logic signed [31:0] motor_cmd,
  output logic display_hold
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  axph_pkg::axph_cfg_t cfg_r, cfg_nxt;
  axph_pkg::axph_mode_t mode_r, mode_nxt;
  logic [axph_pkg::TICK_W-1:0] tcnt_r, tcnt_nxt;
  logic signed [15:0] vel_r, vel_nxt;
  logic signed [31:0] traj_r, traj_nxt, dest_r, dest_nxt;
  logic signed [31:0] ferr_r, ferr_nxt, motor_r, motor_nxt;
  logic hdone_r, hdone_nxt, hold_r, hold_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic tick, wr_en, cmd_move, cmd_home, cmd_stop, load;
  logic signed [31:0] pos, rem, mv_dest;
  logic [31:0] rem_abs;
  logic [15:0] m, jspd, jacc, slow;
  logic [16:0] mnew;
  logic [48:0] bk_l, bk_r;
  logic signed [15:0] rtgt, rnext;
  logic [15:0] racc;
  logic signed [63:0] ctl_sum;
  logic lim_hit, busy, homing;

  // ----------------------------------------------------------------
  // Servo cycle divider
  // ----------------------------------------------------------------
  // One-cycle tick per servo period
  always_comb begin
    tick = (tcnt_r == axph_pkg::TICK_W'(axph_pkg::SERVO_CYC - 1)); // R19
    tcnt_nxt = tick ? '0 : tcnt_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  // Setup phase decodes, access phase completes in its first cycle
  always_comb begin
    wr_en = psel && penable && pwrite && pready_r;
    cmd_move = wr_en && paddr == axph_pkg::OFS_CTRL
               && pwdata[axph_pkg::CTL_MOVE];
    cmd_home = wr_en && paddr == axph_pkg::OFS_CTRL
               && pwdata[axph_pkg::CTL_HOME];
    cmd_stop = wr_en && paddr == axph_pkg::OFS_CTRL
               && pwdata[axph_pkg::CTL_STOP];
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    cfg_nxt = cfg_r;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        axph_pkg::OFS_CTRL: prdata_nxt = {27'h0, cfg_r.jog_sel, 4'h0};
        axph_pkg::OFS_DEST: prdata_nxt = dest_r;
        axph_pkg::OFS_ACC: prdata_nxt = {16'h0, cfg_r.acc};
        axph_pkg::OFS_VEL: prdata_nxt = {16'h0, cfg_r.vmax};
        axph_pkg::OFS_JOGHI: prdata_nxt = {16'h0, cfg_r.jog_hi};
        axph_pkg::OFS_JOGLO: prdata_nxt = {16'h0, cfg_r.jog_lo};
        axph_pkg::OFS_HSPD: prdata_nxt = {16'h0, cfg_r.hspd};
        axph_pkg::OFS_FFGAIN:
          prdata_nxt = {16'h0, cfg_r.velocity_feedforward_gain};
        axph_pkg::OFS_LIMLO: prdata_nxt = cfg_r.lim_lo;
        axph_pkg::OFS_LIMHI: prdata_nxt = cfg_r.lim_hi;
        axph_pkg::OFS_HREF: prdata_nxt = cfg_r.href;
        axph_pkg::OFS_KP: prdata_nxt = {16'h0, cfg_r.kp};
        axph_pkg::OFS_STAT: prdata_nxt = {27'h0, lim_hit, hold_r,
                                          hdone_r, homing, busy};
        axph_pkg::OFS_POS: prdata_nxt = pos;
        axph_pkg::OFS_FERR: prdata_nxt = ferr_r;
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      pslverr_nxt = !(paddr <= axph_pkg::OFS_KP && paddr[1:0] == 2'b00);
    end
    // Live regs: a running profile picks new values up next tick
    if (wr_en) begin
      unique case (paddr)
        axph_pkg::OFS_CTRL: cfg_nxt.jog_sel = pwdata[axph_pkg::CTL_JOGHI];
        axph_pkg::OFS_ACC: cfg_nxt.acc = pwdata[15:0]; // R4
        axph_pkg::OFS_VEL: cfg_nxt.vmax = pwdata[15:0]; // R4
        axph_pkg::OFS_JOGHI: cfg_nxt.jog_hi = pwdata[15:0]; // R6
        axph_pkg::OFS_JOGLO: cfg_nxt.jog_lo = pwdata[15:0]; // R6
        axph_pkg::OFS_HSPD: cfg_nxt.hspd = pwdata[15:0];
        axph_pkg::OFS_FFGAIN:
          cfg_nxt.velocity_feedforward_gain = pwdata[15:0];
        axph_pkg::OFS_LIMLO: cfg_nxt.lim_lo = pwdata;
        axph_pkg::OFS_LIMHI: cfg_nxt.lim_hi = pwdata;
        axph_pkg::OFS_HREF: cfg_nxt.href = pwdata;
        axph_pkg::OFS_KP: cfg_nxt.kp = pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Profile, home sequence and servo output
  // ----------------------------------------------------------------
  // Derived speeds and move braking terms
  always_comb begin
    jspd = cfg_r.jog_sel ? cfg_r.jog_hi : cfg_r.jog_lo; // R6
    jacc = axph_pkg::div_min1(cfg_r.acc, axph_pkg::JOG_DIV); // R7
    slow = axph_pkg::div_min1(cfg_r.hspd, axph_pkg::SLOW_DIV); // R15
    rem = dest_r - traj_r;
    rem_abs = axph_pkg::mag32(rem);
    m = vel_r[15] ? 16'(-vel_r) : 16'(vel_r);
    // Brake once distance left is within v*v/(2a)
    bk_l = 49'(rem_abs) * 49'(cfg_r.acc) * 49'd2;
    bk_r = 49'(m) * 49'(m);
    lim_hit = traj_r >= cfg_r.lim_hi || traj_r <= cfg_r.lim_lo;
    busy = mode_r != axph_pkg::M_IDLE;
    homing = mode_r >= axph_pkg::M_H_A;
    mv_dest = axph_pkg::clamp32( // R10
      pwdata[axph_pkg::CTL_REL] ? traj_r + dest_r : dest_r, // R3
      cfg_r.lim_lo, cfg_r.lim_hi);
  end

  // Ramp goal per mode
  always_comb begin
    racc = cfg_r.acc;
    rtgt = 16'sh0000;
    unique case (mode_r)
      axph_pkg::M_IDLE, axph_pkg::M_MOVE, axph_pkg::M_STOP: ;
      axph_pkg::M_JOG: begin
        racc = jacc; // R7
        if (man.jog_pos && traj_r < cfg_r.lim_hi) // R10
          rtgt = $signed(jspd); // R5
        else if (man.jog_neg && traj_r > cfg_r.lim_lo)
          rtgt = -$signed(jspd); // R5
      end
      axph_pkg::M_H_A: rtgt = -$signed(cfg_r.jog_hi); // R16
      axph_pkg::M_H_B: rtgt = $signed(cfg_r.hspd); // R14
      axph_pkg::M_H_C:
        rtgt = -$signed(cfg_r.hspd / axph_pkg::HALF_DIV); // R14
      axph_pkg::M_H_D, axph_pkg::M_H_E: rtgt = $signed(slow); // R17
      axph_pkg::M_H_ASTOP, axph_pkg::M_H_BSTOP, axph_pkg::M_H_CSTOP: ;
    endcase
  end

  axph_ramp u_ramp (
    .vel(vel_r),
    .tgt(rtgt),
    .acc(racc),
    .vnext(rnext)
  );

  // Mode sequencing; stop command overrides every other mode change
  always_comb begin
    mode_nxt = mode_r;
    vel_nxt = vel_r;
    traj_nxt = traj_r;
    dest_nxt = dest_r;
    ferr_nxt = ferr_r;
    motor_nxt = motor_r;
    hdone_nxt = hdone_r;
    load = 1'b0;
    mnew = 17'h0_0000;
    ctl_sum = 64'sh0;
    if (wr_en && paddr == axph_pkg::OFS_DEST)
      dest_nxt = pwdata;
    if (tick) begin
      ferr_nxt = traj_r - pos; // R19
      vel_nxt = rnext;
      unique case (mode_r)
        axph_pkg::M_IDLE: vel_nxt = 16'sh0000;
        axph_pkg::M_MOVE: begin
          if (rem == 32'sh0) begin
            vel_nxt = 16'sh0000; // R2
            mode_nxt = axph_pkg::M_IDLE;
          end else begin
            if (bk_l <= bk_r) // R2
              mnew = (m > cfg_r.acc) ? 17'(m - cfg_r.acc) : 17'h1;
            else if (17'(m) + 17'(cfg_r.acc) > 17'(cfg_r.vmax))
              mnew = 17'(cfg_r.vmax);
            else
              mnew = 17'(m) + 17'(cfg_r.acc);
            if (32'(mnew) > rem_abs)
              mnew = rem_abs[16:0]; // R2
            vel_nxt = rem[31] ? -$signed(mnew[15:0]) : $signed(mnew[15:0]);
          end
        end
        axph_pkg::M_JOG:
          if (!man.jog_pos && !man.jog_neg && rnext == 16'sh0)
            mode_nxt = axph_pkg::M_IDLE;
        axph_pkg::M_STOP:
          if (rnext == 16'sh0) mode_nxt = axph_pkg::M_IDLE;
        axph_pkg::M_H_A:
          if (!man.home_sw) mode_nxt = axph_pkg::M_H_ASTOP; // R16
        axph_pkg::M_H_ASTOP:
          if (rnext == 16'sh0) mode_nxt = axph_pkg::M_H_B;
        axph_pkg::M_H_B:
          if (man.home_sw) mode_nxt = axph_pkg::M_H_BSTOP; // R14
        axph_pkg::M_H_BSTOP:
          if (rnext == 16'sh0) mode_nxt = axph_pkg::M_H_C; // R14
        axph_pkg::M_H_C:
          if (!man.home_sw) mode_nxt = axph_pkg::M_H_CSTOP;
        axph_pkg::M_H_CSTOP:
          if (rnext == 16'sh0) mode_nxt = axph_pkg::M_H_D; // R15
        axph_pkg::M_H_D:
          if (man.home_sw) mode_nxt = axph_pkg::M_H_E; // R12
        axph_pkg::M_H_E: ;
      endcase
      traj_nxt = traj_r + 32'(vel_nxt);
      // Closed-loop term plus scaled desired velocity
      ctl_sum = 64'(cfg_r.kp) * 64'(ferr_nxt)
        + 64'(cfg_r.velocity_feedforward_gain) * 64'(vel_nxt); // R1
      motor_nxt = ctl_sum[axph_pkg::GAIN_FRAC +: 32]; // R1
    end
    // Index edge ends the search at once, between ticks too
    if (mode_r == axph_pkg::M_H_E && enc.index) begin
      mode_nxt = axph_pkg::M_IDLE; // R21
      vel_nxt = 16'sh0000; // R21
      load = 1'b1; // R21
      traj_nxt = cfg_r.href;
      hdone_nxt = 1'b1; // R21
    end
    if (cmd_stop) begin
      mode_nxt = axph_pkg::M_STOP;
    end else if (mode_r == axph_pkg::M_IDLE) begin
      if (cmd_home) begin
        hdone_nxt = 1'b0;
        mode_nxt = man.home_sw ? axph_pkg::M_H_A : axph_pkg::M_H_B; // R11
      end else if (cmd_move) begin
        dest_nxt = mv_dest; // R3
        mode_nxt = axph_pkg::M_MOVE;
      end else if (man.jog_pos || man.jog_neg) begin
        mode_nxt = axph_pkg::M_JOG; // R5
      end
    end
  end

  axph_quad u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .enc(enc),
    .load(load),
    .load_val(cfg_r.href),
    .pos(pos)
  );

  // Display held off only while the index is being sought
  always_comb hold_nxt = (mode_nxt == axph_pkg::M_H_E); // R13

  // All state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= axph_pkg::CFG_RST;
      mode_r <= axph_pkg::M_IDLE;
      tcnt_r <= '0;
      vel_r <= 16'sh0000;
      traj_r <= 32'sh0000_0000;
      dest_r <= 32'sh0000_0000;
      ferr_r <= 32'sh0000_0000;
      motor_r <= 32'sh0000_0000;
      hdone_r <= 1'b0;
      hold_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      mode_r <= mode_nxt;
      tcnt_r <= tcnt_nxt;
      vel_r <= vel_nxt;
      traj_r <= traj_nxt;
      dest_r <= dest_nxt;
      ferr_r <= ferr_nxt;
      motor_r <= motor_nxt;
      hdone_r <= hdone_nxt;
      hold_r <= hold_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign motor_cmd = motor_r;
  assign display_hold = hold_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_arrive;
    mode_r == axph_pkg::M_MOVE && tick && traj_r == dest_r;
  endsequence

  sequence s_at_rest;
    mode_r == axph_pkg::M_IDLE && vel_r == 16'sh0;
  endsequence

  a_move_rest: assert property (@(posedge pclk) disable iff (!presetn) // R2
    s_arrive |=> s_at_rest)
    else $error("move did not come to rest at destination");

  a_ferr_tick: assert property (@(posedge pclk) disable iff (!presetn) // R19
    tick |=> ferr_r == $past(traj_r) - $past(pos))
    else $error("following error not formed on servo tick");

  a_ff_sum: assert property (@(posedge pclk) disable iff (!presetn) // R1
    tick |=> motor_r == 32'((64'($past(cfg_r.kp)) * 64'(ferr_r)
      + 64'($past(cfg_r.velocity_feedforward_gain)) * 64'(vel_r))
      >>> axph_pkg::GAIN_FRAC))
    else $error("feed-forward term missing from output");

  a_jog_release: assert property (@(posedge pclk) disable iff (!presetn) // R5
    mode_r == axph_pkg::M_JOG && tick && !man.jog_pos && !man.jog_neg
      && m != 16'h0000 |=> m < $past(m))
    else $error("jog did not slow after release");

  a_index_pos: assert property (@(posedge pclk) disable iff (!presetn) // R17
    mode_r == axph_pkg::M_H_E && tick && !enc.index |=> vel_r > 16'sh0)
    else $error("index search not moving positive");

  a_hold_e: assert property (@(posedge pclk) disable iff (!presetn) // R13
    mode_r == axph_pkg::M_H_E |-> hold_r)
    else $error("display not held during index search");

  a_home_end: assert property (@(posedge pclk) disable iff (!presetn) // R21
    mode_r == axph_pkg::M_H_E && enc.index && !cmd_stop |=>
      s_at_rest ##0 hdone_r ##0 pos == $past(cfg_r.href))
    else $error("index did not end homing correctly");

  a_home_dir: assert property (@(posedge pclk) disable iff (!presetn) // R11
    mode_r == axph_pkg::M_IDLE && cmd_home && !cmd_stop |=>
      mode_r == ($past(man.home_sw) ? axph_pkg::M_H_A : axph_pkg::M_H_B))
    else $error("home start direction wrong");

  a_d_to_e: assert property (@(posedge pclk) disable iff (!presetn) // R12
    mode_r == axph_pkg::M_H_D && tick && man.home_sw && !cmd_stop |=>
      mode_r == axph_pkg::M_H_E && vel_r != 16'sh0)
    else $error("stop between final home segments");

endmodule : axph_axis

//--- axph_pkg.sv
// Purpose: constants, types and helpers for the axis profile/home block
// Assumes: 10 MHz pclk, APB register access, one axis
// Notes: velocities are counts per servo cycle, gains are 8.8 fixed point
//
// Overview of operation
// R1: Feed-forward scaled velocity added to control output
// R2: Move accelerates, cruises, brakes to exact rest
// R3: Destination absolute or relative to current position
// R4: Acceleration and velocity changes apply mid-motion
// R5: Jog runs while held, stops on release
// R6: Separate high and low jog speed settings
// R7: Jog acceleration is maximum acceleration over ten
// R8: Position counter follows each decoded encoder step
// R9: Position counter cleared at power-on reset
// R10: Software travel limits bound commanded motion
// R11: Home switch level picks search direction
// R12: Final two home segments slow, no stop
// R13: Display updates held during index search
// R14: Coarse search, overshoot stop, reverse at half
// R15: Overshoot, reverse, finals at tenth speed
// R16: Opposite side: fast move to transition first
// R17: Index search always travels positive
// R18: Host avoids commands during homing except stop
// R19: Following error formed every 400 us servo cycle
// R20: Quadrature decoded four counts per cycle
// R21: Index ends homing: stop, load reference, flag
package axph_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int SERVO_US = 400;
  localparam int SERVO_CYC = SERVO_US * CLK_MHZ;
  localparam int TICK_W = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEST = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_VEL = 8'h0C;
  localparam logic [7:0] OFS_JOGHI = 8'h10;
  localparam logic [7:0] OFS_JOGLO = 8'h14;
  localparam logic [7:0] OFS_HSPD = 8'h18;
  localparam logic [7:0] OFS_FFGAIN = 8'h1C;
  localparam logic [7:0] OFS_LIMLO = 8'h20;
  localparam logic [7:0] OFS_LIMHI = 8'h24;
  localparam logic [7:0] OFS_HREF = 8'h28;
  localparam logic [7:0] OFS_KP = 8'h2C;
  localparam logic [7:0] OFS_STAT = 8'h30;
  localparam logic [7:0] OFS_POS = 8'h34;
  localparam logic [7:0] OFS_FERR = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_MOVE = 0;
  localparam int CTL_REL = 1;
  localparam int CTL_HOME = 2;
  localparam int CTL_STOP = 3;
  localparam int CTL_JOGHI = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_HOMING = 1;
  localparam int ST_HDONE = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_LIMIT = 4;

  // ----------------------------------------------------------------
  // Divisors and scaling
  // ----------------------------------------------------------------
  localparam logic [15:0] JOG_DIV = 16'h000A;
  localparam logic [15:0] HALF_DIV = 16'h0002;
  localparam logic [15:0] SLOW_DIV = 16'h000A;
  localparam int GAIN_FRAC = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ch_a;
    logic ch_b;
    logic index;
  } axph_enc_t;

  typedef struct packed {
    logic jog_pos;
    logic jog_neg;
    logic home_sw;
  } axph_man_t;

  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] vmax;
    logic [15:0] jog_hi;
    logic [15:0] jog_lo;
    logic [15:0] hspd;
    logic signed [15:0] velocity_feedforward_gain;
    logic signed [15:0] kp;
    logic signed [31:0] lim_lo;
    logic signed [31:0] lim_hi;
    logic signed [31:0] href;
    logic jog_sel;
  } axph_cfg_t;

  typedef enum {
    M_IDLE, M_MOVE, M_JOG, M_STOP, M_H_A, M_H_ASTOP, M_H_B,
    M_H_BSTOP, M_H_C, M_H_CSTOP, M_H_D, M_H_E
  } axph_mode_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam axph_cfg_t CFG_RST = '{
    acc: 16'h0010, vmax: 16'h0100, jog_hi: 16'h0080, jog_lo: 16'h0010,
    hspd: 16'h0040, velocity_feedforward_gain: 16'h0000, kp: 16'h0100,
    lim_lo: 32'h8000_0000, lim_hi: 32'h7FFF_FFFF, href: 32'h0000_0000,
    jog_sel: 1'b0};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : mag32

  function automatic logic signed [31:0] clamp32(
      input logic signed [31:0] v, input logic signed [31:0] lo,
      input logic signed [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp32

  // Divided speed, never zero so a slow segment still moves
  function automatic logic [15:0] div_min1(input logic [15:0] v,
                                           input logic [15:0] d);
    logic [15:0] q;
    q = v / d;
    return (q == 16'h0000) ? 16'h0001 : q;
  endfunction : div_min1

endpackage : axph_pkg

//--- axph_plant.sv
// Purpose: motor, encoder and home switch stand-in for the axis
// Assumes: drive value read as steps to take per servo cycle
// Notes: one encoder count per clock at most, no slip
`timescale 1ns/1ps
module axph_plant (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Drive in
  input wire logic signed [31:0] motor_cmd,
  // Sensors out
  output axph_pkg::axph_enc_t enc,
  output logic home_sw,
  output logic signed [31:0] pos
);
  logic [11:0] cnt_r;
  logic signed [31:0] left_r;
  // Latch drive well after the servo update so a held value is not missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
      left_r <= 32'sh0000_0000;
      pos <= 32'sh0000_0000;
    end else begin
      cnt_r <= (cnt_r == 12'hF9F) ? 12'h000 : cnt_r + 12'h001;
      if (cnt_r == 12'h00A) begin
        left_r <= motor_cmd;
      end else if (left_r > 0) begin
        left_r <= left_r - 32'sh0000_0001;
        pos <= pos + 32'sh0000_0001;
      end else if (left_r < 0) begin
        left_r <= left_r + 32'sh0000_0001;
        pos <= pos - 32'sh0000_0001;
      end
    end
  end
  // Gray order 00, 01, 11, 10 means counting up
  assign enc = {pos[1], pos[1] ^ pos[0], pos[5:0] == 6'h00};
  assign home_sw = (pos >= 32'sh0000_01F4);
endmodule : axph_plant

//--- axph_quad.sv
// Purpose: X4 quadrature decode and position counter
// Assumes: encoder inputs already synchronous to pclk
// Notes: load wins over a count in the same cycle
`timescale 1ns/1ps
module axph_quad (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Encoder and counter control
  input wire axph_pkg::axph_enc_t enc,
  input wire logic load,
  input wire logic signed [31:0] load_val,
  // Counter
  output logic signed [31:0] pos
);

  logic [1:0] ab_r, ab_nxt;
  logic signed [31:0] pos_r, pos_nxt;
  logic step_up, step_dn;

  // Gray step direction from previous and present channel pair
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    unique case ({ab_r, enc.ch_a, enc.ch_b})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1; // R20
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1; // R20
      default: ;
    endcase
    ab_nxt = {enc.ch_a, enc.ch_b};
    pos_nxt = pos_r;
    if (load)
      pos_nxt = load_val; // R21
    else if (step_up)
      pos_nxt = pos_r + 32'sd1; // R8
    else if (step_dn)
      pos_nxt = pos_r - 32'sd1; // R8
  end

  // Power-on reset clears the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_r <= 2'b00;
      pos_r <= 32'sh0000_0000; // R9
    end else begin
      ab_r <= ab_nxt;
      pos_r <= pos_nxt;
    end
  end

  assign pos = pos_r;

  a_count_up_dn: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !load && (step_up || step_dn) |=>
      pos_r == $past(pos_r) + (($past(step_up)) ? 32'sd1 : -32'sd1))
    else $error("position count step wrong");

  a_count_held: assert property (@(posedge pclk) disable iff (!presetn) // R20
    !load && $stable({enc.ch_a, enc.ch_b}) ##1
      $stable({enc.ch_a, enc.ch_b}) && !load |-> $stable(pos_r))
    else $error("position moved without encoder edge");

endmodule : axph_quad

//--- axph_ramp.sv
// Purpose: one servo-cycle velocity step toward a target
// Assumes: |target| and acc stay within 15 bits
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
module axph_ramp (
  // Present state and goal
  input wire logic signed [15:0] vel,
  input wire logic signed [15:0] tgt,
  input wire logic [15:0] acc,
  // Next velocity
  output logic signed [15:0] vnext
);

  logic signed [17:0] diff;
  logic signed [17:0] step;

  // Move by at most acc, land exactly on the target
  always_comb begin
    diff = 18'(tgt) - 18'(vel);
    step = $signed({2'b00, acc});
    if (diff > step)
      vnext = 16'(18'(vel) + step);
    else if (diff < -step)
      vnext = 16'(18'(vel) - step);
    else
      vnext = tgt;
  end

endmodule : axph_ramp

//--- tb.sv
// Purpose: register, move, limit and jog checks of the axis
// Assumes: plant stand-in closes the servo loop with unit gain
// Notes: run is about twenty servo cycles long
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, display_hold, sw, jp = 1'b0;
  logic jn = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic signed [31:0] motor_cmd, ppos;
  axph_pkg::axph_enc_t enc;
  int miscompares = 0, total_checks = 0, cyc = 0;
  axph_axis u_axph_axis (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc(enc),
    .man({jp, jn, sw}),
    .motor_cmd(motor_cmd), .display_hold(display_hold));
  axph_plant u_axph_plant (.pclk(pclk), .presetn(presetn),
    .motor_cmd(motor_cmd), .enc(enc), .home_sw(sw), .pos(ppos));
  // Clock and run limit
  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll busy, then give the plant one more servo cycle
  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      apb(axph_pkg::OFS_STAT, 1'b0, 32'h0000_0000);
      if (r[axph_pkg::ST_BUSY] === 1'b0) break;
      repeat (500) @(posedge pclk);
    end
    repeat (4100) @(posedge pclk);
  endtask : wait_idle
  task automatic move(input logic [31:0] d, input logic [31:0] c);
    apb(axph_pkg::OFS_DEST, 1'b1, d);
    apb(axph_pkg::OFS_CTRL, 1'b1, c);
    apb(axph_pkg::OFS_STAT, 1'b0, 32'h0000_0000);
    `CHK(r[axph_pkg::ST_BUSY], 1'b1)
    wait_idle();
    apb(axph_pkg::OFS_POS, 1'b0, 32'h0000_0000);
  endtask : move
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(axph_pkg::OFS_POS, 1'b0, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    apb(axph_pkg::OFS_JOGHI, 1'b0, 32'h0000_0000);
    `CHK(r, 32'h0000_0080)
    apb(axph_pkg::OFS_JOGLO, 1'b1, 32'h0000_0023);
    apb(axph_pkg::OFS_JOGLO, 1'b0, 32'h0000_0000);
    `CHK(r, 32'h0000_0023)
    apb(8'h3C, 1'b0, 32'h0000_0000);
    `CHK({e, r}, {1'b1, 32'h0000_0000})
    move(32'h0000_0064, 32'h0000_0001);
    `CHK(r, 32'h0000_0064)
    `CHK(ppos, 32'sh0000_0064)
    move(32'hFFFF_FFD8, 32'h0000_0003);
    `CHK(r, 32'h0000_003C)
    apb(axph_pkg::OFS_LIMHI, 1'b1, 32'h0000_0050);
    move(32'h0000_00C8, 32'h0000_0001);
    `CHK(r, 32'h0000_0050)
    apb(axph_pkg::OFS_ACC, 1'b1, 32'h0000_00A0);
    jn <= 1'b1;
    repeat (12000) @(posedge pclk);
    apb(axph_pkg::OFS_STAT, 1'b0, 32'h0000_0000);
    `CHK(r[axph_pkg::ST_BUSY], 1'b1)
    jn <= 1'b0;
    wait_idle();
    apb(axph_pkg::OFS_POS, 1'b0, 32'h0000_0000);
    `CHK($signed(r) < 32'sh0000_0050, 1'b1)
    `CHK(r, ppos)
    `CHK(motor_cmd, 32'sh0000_0000)
    `CHK(display_hold, 1'b0)
    end_sim();
  end
endmodule : tb
